// ---- rtl/blit_operation_and_address_setup.sv ----
// Blit operation selector, address registers and job launch sequencer
`timescale 1ns/1ns
module blit_operation_and_address_setup (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [blit_cfg_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic jobActive,
	output blit_cfg_pkg::job_t job,
	output blit_cfg_pkg::pattern_t pattern,
	input wire logic engineDone
);

	function automatic logic [blit_cfg_pkg::IDX_W-1:0] wordIdx(
		input logic [blit_cfg_pkg::ADDR_W-1:0] a);
		return a[blit_cfg_pkg::ADDR_W-1:2];
	endfunction

	function automatic blit_cfg_pkg::op_class_t decodeOp(
		input logic [blit_cfg_pkg::OP_W-1:0] op);
		blit_cfg_pkg::op_class_t c;
		c = '0;
		c.valid = 1'b1;
		case (op)
			blit_cfg_pkg::OP_WRITE_ROP: c.hostWrite = 1'b1;
			blit_cfg_pkg::OP_READ: c.hostRead = 1'b1;
			blit_cfg_pkg::OP_MOVE_POS: c.memMove = 1'b1;
			blit_cfg_pkg::OP_MOVE_NEG: begin
				c.memMove = 1'b1;
				c.negDir = 1'b1;
			end
			blit_cfg_pkg::OP_TWRITE: begin
				c.hostWrite = 1'b1;
				c.transparent = 1'b1;
			end
			blit_cfg_pkg::OP_TMOVE: begin
				c.memMove = 1'b1;
				c.transparent = 1'b1;
			end
			blit_cfg_pkg::OP_PAT_ROP: c.patternFill = 1'b1;
			blit_cfg_pkg::OP_PAT_TRANS: begin
				c.patternFill = 1'b1;
				c.transparent = 1'b1;
			end
			blit_cfg_pkg::OP_CEXP: begin
				c.hostWrite = 1'b1;
				c.colorExpand = 1'b1;
			end
			blit_cfg_pkg::OP_CEXP_TRANS: begin
				c.hostWrite = 1'b1;
				c.colorExpand = 1'b1;
				c.transparent = 1'b1;
			end
			blit_cfg_pkg::OP_MOVE_CEXP: begin
				c.memMove = 1'b1;
				c.colorExpand = 1'b1;
			end
			blit_cfg_pkg::OP_MOVE_CEXP_T: begin
				c.memMove = 1'b1;
				c.colorExpand = 1'b1;
				c.transparent = 1'b1;
			end
			blit_cfg_pkg::OP_SOLID: c.solidFill = 1'b1;
			default: c = '0;
		endcase
		return c;
	endfunction

	logic busReq;
	logic wrEn;
	logic [blit_cfg_pkg::IDX_W-1:0] idx;
	logic [31:0] readMux;
	logic next_ack;
	logic [31:0] next_datOut;

	logic [blit_cfg_pkg::OP_W-1:0] opSel, next_opSel;
	logic [blit_cfg_pkg::XADDR_W-1:0] srcAddr, next_srcAddr;
	logic [blit_cfg_pkg::XADDR_W-1:0] dstAddr, next_dstAddr;
	logic [blit_cfg_pkg::WIDTH_W-1:0] widthM1, next_widthM1;
	logic depth16, next_depth16;

	blit_cfg_pkg::state_t state, next_state;
	blit_cfg_pkg::job_t next_job;
	blit_cfg_pkg::op_class_t opCls;
	logic rsvdFlag, next_rsvdFlag;
	logic startReq;

	assign busReq = wb_cyc_i && wb_stb_i;
	assign idx = wordIdx(wb_adr_i);
	// Writes land on the edge that samples ack high
	assign wrEn = busReq && wb_ack_o && wb_we_i && wb_sel_i[0];
	assign startReq = wrEn && idx == blit_cfg_pkg::IDX_CTRL
		&& wb_dat_i[blit_cfg_pkg::START_BIT];
	assign opCls = decodeOp(opSel);
	assign jobActive = state == blit_cfg_pkg::ST_RUN;

	// Read view; unmapped and reserved bits read zero
	always_comb begin
		readMux = 32'h00000000;
		case (idx)
			blit_cfg_pkg::IDX_CTRL: begin
				readMux[blit_cfg_pkg::BUSY_BIT] = jobActive;
				readMux[blit_cfg_pkg::RSVD_FLAG_BIT] = rsvdFlag;
			end
			blit_cfg_pkg::IDX_FMT: readMux[blit_cfg_pkg::DEPTH_BIT] = depth16;
			blit_cfg_pkg::IDX_OPSEL: readMux[3:0] = opSel;
			blit_cfg_pkg::IDX_SRC0: readMux[7:0] = srcAddr[7:0];
			blit_cfg_pkg::IDX_SRC1: readMux[7:0] = srcAddr[15:8];
			blit_cfg_pkg::IDX_SRC2: readMux[4:0] = srcAddr[20:16];
			blit_cfg_pkg::IDX_DST0: readMux[7:0] = dstAddr[7:0];
			blit_cfg_pkg::IDX_DST1: readMux[7:0] = dstAddr[15:8];
			blit_cfg_pkg::IDX_DST2: readMux[4:0] = dstAddr[20:16];
			blit_cfg_pkg::IDX_WID0: readMux[7:0] = widthM1[7:0];
			blit_cfg_pkg::IDX_WID1: readMux[1:0] = widthM1[9:8];
			default: readMux = 32'h00000000;
		endcase
	end

	// Bus slave: ack one cycle after request, one cycle long
	always_comb begin
		next_ack = busReq && !wb_ack_o;
		next_datOut = wb_dat_o;
		if (busReq && !wb_ack_o) begin
			next_datOut = readMux;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (clkEn) begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_datOut;
		end
	end

	// Register file writes
	always_comb begin
		next_opSel = opSel;
		next_srcAddr = srcAddr;
		next_dstAddr = dstAddr;
		next_widthM1 = widthM1;
		next_depth16 = depth16;
		if (wrEn) begin
			case (idx)
				blit_cfg_pkg::IDX_FMT:
					next_depth16 = wb_dat_i[blit_cfg_pkg::DEPTH_BIT];
				blit_cfg_pkg::IDX_OPSEL: next_opSel = wb_dat_i[3:0];
				blit_cfg_pkg::IDX_SRC0: next_srcAddr[7:0] = wb_dat_i[7:0];
				blit_cfg_pkg::IDX_SRC1: next_srcAddr[15:8] = wb_dat_i[7:0];
				blit_cfg_pkg::IDX_SRC2:
					next_srcAddr[20:16] = wb_dat_i[4:0];
				blit_cfg_pkg::IDX_DST0: next_dstAddr[7:0] = wb_dat_i[7:0];
				blit_cfg_pkg::IDX_DST1: next_dstAddr[15:8] = wb_dat_i[7:0];
				blit_cfg_pkg::IDX_DST2:
					next_dstAddr[20:16] = wb_dat_i[4:0];
				blit_cfg_pkg::IDX_WID0: next_widthM1[7:0] = wb_dat_i[7:0];
				blit_cfg_pkg::IDX_WID1:
					next_widthM1[9:8] = wb_dat_i[1:0];
				default: next_opSel = opSel;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			opSel <= blit_cfg_pkg::OPSEL_RST;
			srcAddr <= blit_cfg_pkg::ADDR_RST;
			dstAddr <= blit_cfg_pkg::ADDR_RST;
			widthM1 <= blit_cfg_pkg::WIDTH_RST;
			depth16 <= blit_cfg_pkg::DEPTH_RST;
		end else if (clkEn) begin
			opSel <= next_opSel;
			srcAddr <= next_srcAddr;
			dstAddr <= next_dstAddr;
			widthM1 <= next_widthM1;
			depth16 <= next_depth16;
		end
	end

	// Launch sequencer: snapshot the setup at start
	always_comb begin
		next_state = state;
		next_job = job;
		next_rsvdFlag = rsvdFlag;
		case (state)
			blit_cfg_pkg::ST_IDLE: begin
				if (startReq && opCls.valid) begin
					next_state = blit_cfg_pkg::ST_RUN;
					next_rsvdFlag = 1'b0;
					next_job.op = opSel;
					next_job.cls = opCls;
					next_job.srcAddr = srcAddr;
					next_job.dstAddr = dstAddr;
					next_job.widthM1 = widthM1;
					next_job.depth16 = depth16;
					if (opCls.hostWrite) begin
						next_job.srcAddr = {20'h00000, srcAddr[0]};
					end
				end else if (startReq) begin
					next_rsvdFlag = 1'b1;
				end
			end
			blit_cfg_pkg::ST_RUN: begin
				if (engineDone) begin
					next_state = blit_cfg_pkg::ST_IDLE;
				end
			end
			default: next_state = blit_cfg_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= blit_cfg_pkg::ST_IDLE;
			job <= '0;
			rsvdFlag <= 1'b0;
		end else if (clkEn) begin
			state <= next_state;
			job <= next_job;
			rsvdFlag <= next_rsvdFlag;
		end
	end

	blit_pattern_split split (
		.srcAddr(job.srcAddr),
		.depth16(job.depth16),
		.pattern(pattern)
	);

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	op_store_a: assert property (clkEn && wrEn
		&& idx == blit_cfg_pkg::IDX_OPSEL |=> opSel == $past(wb_dat_i[3:0]))
		else $error("operation code not stored");
	op_upper_a: assert property (wb_ack_o && !wb_we_i
		&& idx == blit_cfg_pkg::IDX_OPSEL |-> wb_dat_o[31:4] == 28'h0)
		else $error("operation register upper bits not zero");
	src_high_a: assert property (wb_ack_o && !wb_we_i
		&& idx == blit_cfg_pkg::IDX_SRC2 |-> wb_dat_o[31:5] == 27'h0)
		else $error("source high byte reads beyond bit 4");
	dst_high_a: assert property (wb_ack_o && !wb_we_i
		&& idx == blit_cfg_pkg::IDX_DST2 |-> wb_dat_o[31:5] == 27'h0)
		else $error("destination high byte reads beyond bit 4");
	launch_job_a: assert property (clkEn && !jobActive && startReq
		&& opCls.valid |=> jobActive && job.op == $past(opSel)
		&& job.dstAddr == $past(dstAddr))
		else $error("valid start did not launch the job");
	reserved_idle_a: assert property (clkEn && !jobActive
		&& startReq && !opCls.valid |=> !jobActive && rsvdFlag)
		else $error("reserved code started a job");
	host_src_a: assert property (jobActive && job.cls.hostWrite
		|-> job.srcAddr[20:1] == 20'h0)
		else $error("host job kept upper source bits");
	neg_move_a: assert property (jobActive
		&& job.op == blit_cfg_pkg::OP_MOVE_NEG
		|-> job.cls.memMove && job.cls.negDir)
		else $error("negative move decoded wrongly");
	pat_8bpp_a: assert property (jobActive && !job.depth16
		|-> pattern.base + {pattern.line, 3'h0} + pattern.pix
		== job.srcAddr && pattern.base[5:0] == 6'h00)
		else $error("8 bpp pattern split wrong");
	pat_16bpp_a: assert property (jobActive && job.depth16
		|-> pattern.base + {pattern.line, 4'h0} + pattern.pix
		== job.srcAddr && pattern.base[6:0] == 7'h00)
		else $error("16 bpp pattern split wrong");
	run_hold_a: assert property (clkEn && jobActive && !engineDone
		|=> jobActive)
		else $error("job dropped before engine done");
	ack_pulse_a: assert property (clkEn && wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	start_cv: cover property (startReq && opCls.valid ##1 jobActive);
	reserved_cv: cover property (startReq && !opCls.valid);
	pattern_cv: cover property (jobActive && job.cls.patternFill);
	read_cv: cover property (wb_ack_o && !wb_we_i);

endmodule

// ---- pkg/blit_cfg_pkg.sv ----
// Register map, field layout, op codes and carrier types of the blit setup
package blit_cfg_pkg;

	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CTRL = 10'h100;
	localparam logic [IDX_W-1:0] IDX_FMT = 10'h101;
	localparam logic [IDX_W-1:0] IDX_OPSEL = 10'h103;
	localparam logic [IDX_W-1:0] IDX_SRC0 = 10'h104;
	localparam logic [IDX_W-1:0] IDX_SRC1 = 10'h105;
	localparam logic [IDX_W-1:0] IDX_SRC2 = 10'h106;
	localparam logic [IDX_W-1:0] IDX_DST0 = 10'h108;
	localparam logic [IDX_W-1:0] IDX_DST1 = 10'h109;
	localparam logic [IDX_W-1:0] IDX_DST2 = 10'h10A;
	localparam logic [IDX_W-1:0] IDX_WID0 = 10'h110;
	localparam logic [IDX_W-1:0] IDX_WID1 = 10'h111;

	// Field positions and widths
	localparam int START_BIT = 7;
	localparam int BUSY_BIT = 7;
	localparam int RSVD_FLAG_BIT = 3;
	localparam int DEPTH_BIT = 0;
	localparam int OP_W = 4;
	localparam int XADDR_W = 21;
	localparam int HIGH_ADDR_W = 5;
	localparam int WIDTH_W = 10;
	localparam int WID_HIGH_W = 2;

	// Reset values
	localparam logic [OP_W-1:0] OPSEL_RST = 4'h0;
	localparam logic [XADDR_W-1:0] ADDR_RST = 21'h000000;
	localparam logic [WIDTH_W-1:0] WIDTH_RST = 10'h000;
	localparam logic DEPTH_RST = 1'b0;

	// Operation codes
	localparam logic [OP_W-1:0] OP_WRITE_ROP = 4'h0;
	localparam logic [OP_W-1:0] OP_READ = 4'h1;
	localparam logic [OP_W-1:0] OP_MOVE_POS = 4'h2;
	localparam logic [OP_W-1:0] OP_MOVE_NEG = 4'h3;
	localparam logic [OP_W-1:0] OP_TWRITE = 4'h4;
	localparam logic [OP_W-1:0] OP_TMOVE = 4'h5;
	localparam logic [OP_W-1:0] OP_PAT_ROP = 4'h6;
	localparam logic [OP_W-1:0] OP_PAT_TRANS = 4'h7;
	localparam logic [OP_W-1:0] OP_CEXP = 4'h8;
	localparam logic [OP_W-1:0] OP_CEXP_TRANS = 4'h9;
	localparam logic [OP_W-1:0] OP_MOVE_CEXP = 4'hA;
	localparam logic [OP_W-1:0] OP_MOVE_CEXP_T = 4'hB;
	localparam logic [OP_W-1:0] OP_SOLID = 4'hC;

	typedef enum {ST_IDLE, ST_RUN} state_t;

	typedef struct packed {
		logic valid;
		logic hostWrite;
		logic hostRead;
		logic memMove;
		logic negDir;
		logic transparent;
		logic patternFill;
		logic colorExpand;
		logic solidFill;
	} op_class_t;

	typedef struct packed {
		logic [OP_W-1:0] op;
		op_class_t cls;
		logic [XADDR_W-1:0] srcAddr;
		logic [XADDR_W-1:0] dstAddr;
		logic [WIDTH_W-1:0] widthM1;
		logic depth16;
	} job_t;

	typedef struct packed {
		logic [XADDR_W-1:0] base;
		logic [2:0] line;
		logic [3:0] pix;
	} pattern_t;

endpackage

// ---- rtl/blit_pattern_split.sv ----
// Splits the pattern-fill source address into base, line and pixel parts
`timescale 1ns/1ns
module blit_pattern_split (
	input wire logic [blit_cfg_pkg::XADDR_W-1:0] srcAddr,
	input wire logic depth16,
	output blit_cfg_pkg::pattern_t pattern
);

	always_comb begin
		if (depth16) begin
			pattern.base = {srcAddr[20:7], 7'h00};
			pattern.line = srcAddr[6:4];
			pattern.pix = srcAddr[3:0];
		end else begin
			pattern.base = {srcAddr[20:6], 6'h00};
			pattern.line = srcAddr[5:3];
			pattern.pix = {1'b0, srcAddr[2:0]};
		end
	end

endmodule

// ---- tb/blit_operation_and_address_setup_bench.sv ----
// Self-checking bench for the blit operation and address setup block
`timescale 1ns/1ns
module blit_operation_and_address_setup_bench;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic clkEn = 1'b1;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [11:0] wbAdr = 12'h000;
	logic [3:0] wbSel = 4'hF;
	logic [31:0] wbDat = 32'h00000000;
	logic [31:0] wbDatO;
	logic wbAck;
	logic jobActive;
	logic engineDone = 1'b0;
	blit_cfg_pkg::job_t job;
	blit_cfg_pkg::pattern_t pattern;
	logic [15:0] seed = 16'h0059;
	logic [31:0] rd;
	logic [9:0] regIdx [9] = '{10'h103, 10'h104, 10'h105, 10'h106, 10'h108,
		10'h109, 10'h10A, 10'h110, 10'h111};
	logic [7:0] regMask [9] = '{8'h0F, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF,
		8'h1F, 8'hFF, 8'h03};
	int fail_count = 0;
	int cmp_count = 0;

	always #25 core_clk = ~core_clk;

	blit_operation_and_address_setup i_blit_operation_and_address_setup (
		.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .jobActive(jobActive),
		.job(job), .pattern(pattern), .engineDone(engineDone)
	);

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	// Host-sourced jobs keep only the byte select bit
	function automatic logic [20:0] exp_src(input logic [3:0] op,
		input logic [20:0] a);
		if (op inside {4'h0, 4'h4, 4'h8, 4'h9})
			return {20'h00000, a[0]};
		return a;
	endfunction

	function automatic blit_cfg_pkg::pattern_t exp_pat(input logic [20:0] a,
		input logic d16);
		blit_cfg_pkg::pattern_t p;
		if (d16) begin
			p.base = {a[20:7], 7'h00};
			p.line = a[6:4];
			p.pix = a[3:0];
		end else begin
			p.base = {a[20:6], 6'h00};
			p.line = a[5:3];
			p.pix = {1'b0, a[2:0]};
		end
		return p;
	endfunction

	function automatic blit_cfg_pkg::op_class_t exp_cls(input logic [3:0] op);
		blit_cfg_pkg::op_class_t c;
		c.valid = op <= 4'hC;
		c.hostWrite = op inside {4'h0, 4'h4, 4'h8, 4'h9};
		c.hostRead = op == 4'h1;
		c.memMove = op inside {4'h2, 4'h3, 4'h5, 4'hA, 4'hB};
		c.negDir = op == 4'h3;
		c.transparent = op inside {4'h4, 4'h5, 4'h7, 4'h9, 4'hB};
		c.patternFill = op inside {4'h6, 4'h7};
		c.colorExpand = op inside {4'h8, 4'h9, 4'hA, 4'hB};
		c.solidFill = op == 4'hC;
		return c;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Classic single cycle; result lands in rd
	task automatic wb(input logic we, input logic [9:0] idx,
		input logic [7:0] d, input logic [3:0] sel = 4'hF);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'b00};
		wbDat <= {24'h000000, d};
		wbSel <= sel;
		// Only the watchdog ends a wait for ack
		do begin
			@(posedge core_clk);
		end while (wbAck !== 1'b1);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wait_active(input logic lvl);
		int n;
		n = 0;
		while (jobActive !== lvl && n < 8) begin
			@(posedge core_clk);
			n++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		give_verdict();
	end

	initial begin
		logic [20:0] src;
		logic [20:0] dst;
		logic [9:0] wid;
		logic [15:0] r;
		logic [3:0] op;
		logic d16;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		foreach (regIdx[i]) begin
			wb(1'b0, regIdx[i], 8'h00);
			check(rd, 32'h00000000);
		end
		for (int k = 0; k < 3; k++) begin
			foreach (regIdx[i]) begin
				r = rnd();
				wb(1'b1, regIdx[i], r[7:0]);
				wb(1'b0, regIdx[i], 8'h00);
				check(rd, {24'h000000, r[7:0] & regMask[i]});
			end
		end
		wb(1'b1, blit_cfg_pkg::IDX_OPSEL, 8'h05);
		wb(1'b1, blit_cfg_pkg::IDX_OPSEL, 8'h0A, 4'hE);
		wb(1'b0, blit_cfg_pkg::IDX_OPSEL, 8'h00);
		check(rd, 32'h00000005);
		wb(1'b1, 10'h3FF, 8'hFF);
		wb(1'b0, 10'h3FF, 8'h00);
		check(rd, 32'h00000000);
		$display("register test done");
		// Every code at both pixel depths
		for (int k = 0; k < 32; k++) begin
			op = k[3:0];
			d16 = k[4];
			r = rnd();
			src = {r[4:0], rnd()};
			r = rnd();
			dst = {r[4:0], rnd()};
			wid = r[15:6] | 10'h001;
			wb(1'b1, blit_cfg_pkg::IDX_OPSEL, {4'h0, op});
			wb(1'b1, blit_cfg_pkg::IDX_SRC0, src[7:0]);
			wb(1'b1, blit_cfg_pkg::IDX_SRC1, src[15:8]);
			wb(1'b1, blit_cfg_pkg::IDX_SRC2, {3'h0, src[20:16]});
			wb(1'b1, blit_cfg_pkg::IDX_DST0, dst[7:0]);
			wb(1'b1, blit_cfg_pkg::IDX_DST1, dst[15:8]);
			wb(1'b1, blit_cfg_pkg::IDX_DST2, {3'h0, dst[20:16]});
			wb(1'b1, blit_cfg_pkg::IDX_FMT, {7'h00, d16});
			wb(1'b1, blit_cfg_pkg::IDX_WID0, wid[7:0]);
			wb(1'b1, blit_cfg_pkg::IDX_WID1, {6'h00, wid[9:8]});
			wb(1'b1, blit_cfg_pkg::IDX_CTRL, 8'h80);
			if (op <= 4'hC) begin
				wait_active(1'b1);
				check(jobActive, 1'b1);
				check(job.op, op);
				check(job.cls, exp_cls(op));
				check(job.srcAddr, exp_src(op, src));
				check(job.dstAddr, dst);
				check(job.widthM1, wid);
				check(job.depth16, d16);
				if (op inside {4'h6, 4'h7})
					check(pattern, exp_pat(src, d16));
				// Second start while busy must not relaunch
				wb(1'b1, blit_cfg_pkg::IDX_OPSEL, 8'h0C);
				wb(1'b1, blit_cfg_pkg::IDX_CTRL, 8'h80);
				wb(1'b0, blit_cfg_pkg::IDX_CTRL, 8'h00);
				check(rd[7], 1'b1);
				check(job.op, op);
				// Done while frozen must not end the job
				clkEn <= 1'b0;
				engineDone <= 1'b1;
				@(posedge core_clk);
				engineDone <= 1'b0;
				clkEn <= 1'b1;
				@(posedge core_clk);
				check(jobActive, 1'b1);
				engineDone <= 1'b1;
				@(posedge core_clk);
				engineDone <= 1'b0;
				wait_active(1'b0);
				check(jobActive, 1'b0);
			end else begin
				repeat (4) @(posedge core_clk);
				check(jobActive, 1'b0);
				wb(1'b0, blit_cfg_pkg::IDX_CTRL, 8'h00);
				check(rd[7], 1'b0);
				check(rd[3], 1'b1);
			end
		end
		$display("operation test done");
		give_verdict();
	end
endmodule
